// *** bench/pflss_props.sv ***
// checker: override outputs against a shadow control word
// assumes i_ce held high by the bench
`timescale 1ns/1ps
module pflss_props #(parameter int NCMP = 4) (
  input wire logic                   i_clk_sys,
  input wire logic                   i_rst,
  input wire logic                   i_wr,
  input wire logic [3:0]             i_addr,
  input wire logic [15:0]            i_wdata,
  input wire pflss_pkg::pflss_data_t i_data,
  input wire logic [NCMP-1:0]        i_cmp,
  input wire logic                   o_high_side_output,
  input wire logic                   o_low_side_output,
  input wire logic                   o_lim_active,
  input wire logic                   o_flt_active
);
  logic [15:0] c_ff;
  wire  [1:0]  hl = {o_high_side_output, o_low_side_output};
  // shadow of the control word
  always_ff @(posedge i_clk_sys)
    if (i_rst) c_ff <= 16'h0000;
    else if (i_wr && i_addr == 4'h0) c_ff <= i_wdata;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  sequence s_held; $stable(c_ff); endsequence
  property p_ind; s_held ##0 c_ff[15] && o_lim_active && !o_flt_active
    |-> o_high_side_output == $past(i_data.flt_data[1]); endproperty
  property p_nflt; s_held ##0 !c_ff[15] && o_flt_active
    |-> hl == $past(i_data.flt_data); endproperty
  property p_nlim; s_held ##0 !c_ff[15] && o_lim_active && !o_flt_active
    |-> hl == $past(i_data.lim_data); endproperty
  property p_rsv; s_held ##0 c_ff[14:10] == 5'h1f |-> !o_lim_active;
  endproperty
  property p_cmp1; s_held ##0 c_ff[14:8] == 7'h01 && $past(i_cmp[0])
    |-> o_lim_active; endproperty
  property p_cmp2; s_held ##0 c_ff[14:8] == 7'h05 && $past(i_cmp[1])
    |-> o_lim_active; endproperty
  a_ind: assert property (p_ind) else $error("ind high");
  a_nflt: assert property (p_nflt) else $error("nrm fault");
  a_nlim: assert property (p_nlim) else $error("nrm limit");
  a_rsv: assert property (p_rsv) else $error("reserved");
  a_cmp1: assert property (p_cmp1) else $error("cmp one");
  a_cmp2: assert property (p_cmp2) else $error("cmp two");
endmodule
bind pflss_top pflss_props #(.NCMP(NCMP)) u_props (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wr(i_wr), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_data(i_data), .i_cmp(i_cmp),
  .o_high_side_output(o_high_side_output),
  .o_low_side_output(o_low_side_output),
  .o_lim_active(o_lim_active), .o_flt_active(o_flt_active));

// *** bench/pflss_src_model.sv ***
// comparator and fault line model, one source high at a time
// assumes codes 4..7 and 31 mean all quiet
`timescale 1ns/1ps
module pflss_src_model (
  input  wire logic        i_clk_sys,
  input  wire logic [4:0]  i_code,
  output logic      [3:0]  o_cmp,
  output logic      [22:0] o_flt
);
  // 0..3 comparators, 8..30 fault lines 1..23
  always_ff @(posedge i_clk_sys) begin
    o_cmp <= (i_code < 5'h04) ? 4'h1 << i_code : 4'h0;
    o_flt <= (i_code[4:3] != 2'h0 && i_code != 5'h1f)
      ? 23'h1 << (i_code - 5'h08) : 23'h0;
  end
endmodule

// *** bench/test_pflss_top.sv ***
// bench: registers, every source code, override modes
// assumes the source model drives comparators and fault lines
`timescale 1ns/1ps
module test_pflss_top;
  logic clk = 0, rst = 1, wr = 0, rd = 0, h, l, la, fa;
  logic [3:0] adr = 4'h0, cmp;
  logic [15:0] wd = 16'h0000, rdat;
  logic [4:0] code = 5'h1f;
  logic [5:0] x = 6'h00;
  logic [22:0] flt;
  int bad_count = 0, n_compared = 0;
  always #5 clk = ~clk;
  pflss_src_model src_u (.i_clk_sys(clk), .i_code(code), .o_cmp(cmp),
    .o_flt(flt));
  pflss_top dut_u (.i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_addr(adr),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_data(x[3:0]),
    .i_cmp(cmp), .i_flt(flt), .i_pwm_h(x[5]), .i_pwm_l(x[4]),
    .o_high_side_output(h), .o_low_side_output(l), .o_lim_active(la),
    .o_flt_active(fa));
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // write, then let source and outputs settle; no time base here
  task put(input logic [15:0] d, input logic [4:0] s, input logic [5:0] v);
    @(posedge clk);
    {wr, wd, code, x} <= {1'b1, d, s, v};
    @(posedge clk);
    wr <= 0;
    repeat (4) @(negedge clk);
  endtask
  task get(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    {adr, rd} <= {a, 1'b1};
    @(posedge clk);
    {adr, rd} <= 5'h00;
    @(negedge clk);
    chk(rdat, e);
  endtask
  task t_src;
    for (int k = 0; k < 32; k++) begin
      put({1'b0, 5'(k), 10'h1fb}, 5'(k), 6'h18);
      chk({la, fa, h, l}, (k < 4 || (k > 7 && k < 31)) ? 4'ha : 4'h1);
    end
    $display("source test done");
  endtask
  task t_ind;
    put({1'b1, 5'h00, 10'h1fb}, 5'h00, 6'h02);
    chk({la, fa, h, l}, 4'ha);
    put({1'b1, 5'h1f, 10'h041}, 5'h08, 6'h01);
    chk({la, fa, h, l}, 4'h5);
    put({1'b0, 5'h1f, 10'h041}, 5'h08, 6'h21);
    chk({la, fa, h, l}, 4'h5);
    $display("mode test done");
  endtask
  // latched fault, status word, release by mode change, fault polarity
  task t_flt;
    put(16'h7c40, 5'h08, 6'h13);
    chk({la, fa, h, l}, 4'h7);
    get(4'h1, 16'h000e);
    put(16'h7c40, 5'h1f, 6'h13);
    chk({la, fa, h, l}, 4'h7);
    get(4'h1, 16'h000a);
    put(16'h7c41, 5'h1f, 6'h13);
    chk({la, fa, h, l}, 4'h1);
    put(16'h7c45, 5'h1f, 6'h13);
    chk({la, fa, h, l}, 4'h7);
    $display("latch test done");
  endtask
  task results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    get(4'h0, 16'h0000);
    put(16'ha5c3, 5'h1f, 6'h00);
    get(4'h0, 16'ha5c3);
    @(posedge clk);
    adr <= 4'hf;
    put(16'hffff, 5'h1f, 6'h00);
    get(4'hf, 16'h0000);
    get(4'h0, 16'ha5c3);
    t_src;
    t_ind;
    t_flt;
    results;
  end
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    results;
  end
endmodule

// *** rtl/pflss_pkg.sv ***
// package for the fault and current-limit source select block
// assumes a single 100 MHz clock and a plain register port
// Behaviour
// - independent mode: limit overrides high side only, fault low side only
// - independent mode ignores limit data; fault data bit1 high, bit0 low
// - normal mode: active limit or fault forces both outputs to its data
// - five-bit limit selector: 00000 comparator one, 00001 comparator two
// - code 11111 reserved; middle codes map to fault lines 1..23 or reserved
package pflss_pkg;
  // register map
  localparam logic [3:0]  ADDR_FLT_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h1;
  localparam logic [15:0] FLT_CTRL_RESET  = 16'h0000;
  // field positions in fault_limit_control
  localparam int POS_IND_MODE  = 15;
  localparam int POS_LIM_SRC   = 10;
  localparam int POS_LIM_POL   = 9;
  localparam int POS_LIM_EN    = 8;
  localparam int POS_FLT_SRC   = 3;
  localparam int POS_FLT_POL   = 2;
  localparam int POS_FLT_MODE  = 0;
  // source selector codes
  localparam logic [4:0] SRC_CMP_FIRST = 5'h00;
  localparam logic [4:0] SRC_CMP_LAST  = 5'h03;
  localparam logic [4:0] SRC_FLT_FIRST = 5'h08;
  localparam logic [4:0] SRC_FLT_LAST  = 5'h1e;
  localparam logic [4:0] SRC_RESERVED  = 5'h1f;
  localparam int NUM_CMP = 4;
  localparam int NUM_FLT = 23;
  // fault mode field codes
  localparam logic [1:0] FMODE_LATCH  = 2'h0;
  localparam logic [1:0] FMODE_CYCLE  = 2'h1;
  localparam logic [1:0] FMODE_OFF    = 2'h3;

  typedef struct packed {
    logic       ind_mode;
    logic [4:0] lim_src;
    logic       lim_pol;
    logic       lim_en;
    logic [4:0] flt_src;
    logic       flt_pol;
    logic [1:0] flt_mode;
  } pflss_ctrl_t;

  typedef struct packed {
    logic [1:0] lim_data;
    logic [1:0] flt_data;
  } pflss_data_t;
endpackage

// *** rtl/pflss_src_mux.sv ***
// source selector: picks one comparator or fault line by a five-bit code
// assumes inputs synchronous to the clock
`timescale 1ns/1ps
module pflss_src_mux #(
  parameter int NCMP = pflss_pkg::NUM_CMP,
  parameter int NFLT = pflss_pkg::NUM_FLT
) (
  input  wire logic [4:0]      i_sel,
  input  wire logic [NCMP-1:0] i_cmp,
  input  wire logic [NFLT-1:0] i_flt,
  output logic                 o_src
);
  import pflss_pkg::*;
  // decode selector; reserved codes give zero
  always_comb begin
    o_src = 1'b0;
    if (i_sel <= SRC_CMP_LAST) begin
      o_src = i_cmp[i_sel[1:0]];
    end else if (i_sel >= SRC_FLT_FIRST && i_sel <= SRC_FLT_LAST) begin
      o_src = i_flt[i_sel - SRC_FLT_FIRST];
    end else begin
      o_src = 1'b0;
    end
  end
endmodule

// *** rtl/pflss_top.sv ***
// fault and current-limit source select and output override
// assumes register strobes and inputs synchronous to i_clk_sys
`timescale 1ns/1ps
module pflss_top #(
  parameter int NCMP = pflss_pkg::NUM_CMP,
  parameter int NFLT = pflss_pkg::NUM_FLT
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  input  wire logic [3:0]           i_addr,
  input  wire logic [15:0]          i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [15:0]          o_rdata,
  input  wire pflss_pkg::pflss_data_t i_data,
  input  wire logic [NCMP-1:0]      i_cmp,
  input  wire logic [NFLT-1:0]      i_flt,
  input  wire logic                 i_pwm_h,
  input  wire logic                 i_pwm_l,
  output logic                      o_high_side_output,
  output logic                      o_low_side_output,
  output logic                      o_lim_active,
  output logic                      o_flt_active
);
  import pflss_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // control register
  pflss_ctrl_t ctrl_ff;
  logic        flt_latch_ff;
  logic        lim_raw;
  logic        flt_raw;
  logic        lim_act;
  logic        flt_act;
  logic        nxt_h;
  logic        nxt_l;

  // software writes; best done with time base stopped
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl_ff <= pflss_ctrl_t'(FLT_CTRL_RESET);
    end else if (i_ce && i_wr && i_addr == ADDR_FLT_CTRL) begin
      ctrl_ff <= pflss_ctrl_t'(i_wdata);
    end
  end

  // read data one cycle after strobe, zero otherwise
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_ce) begin
      o_rdata <= 16'h0000;
      if (i_rd && i_addr == ADDR_FLT_CTRL) begin
        o_rdata <= 16'(ctrl_ff);
      end else if (i_rd && i_addr == ADDR_STATUS) begin
        o_rdata <= {12'h000, flt_latch_ff, flt_act, o_flt_active,
                    o_lim_active};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // source selection
  pflss_src_mux #(.NCMP(NCMP), .NFLT(NFLT)) u_lim_mux (
    .i_sel (ctrl_ff.lim_src),
    .i_cmp (i_cmp),
    .i_flt (i_flt),
    .o_src (lim_raw)
  );
  pflss_src_mux #(.NCMP(NCMP), .NFLT(NFLT)) u_flt_mux (
    .i_sel (ctrl_ff.flt_src),
    .i_cmp (i_cmp),
    .i_flt (i_flt),
    .o_src (flt_raw)
  );

  // polarity and enable; code 11111 never asserts, codes 4..7 assert when polarity is inverted
  always_comb begin
    lim_act = ctrl_ff.lim_en && (lim_raw ^ ctrl_ff.lim_pol)
              && ctrl_ff.lim_src != SRC_RESERVED;
    flt_act = ctrl_ff.flt_mode != FMODE_OFF
              && (flt_raw ^ ctrl_ff.flt_pol)
              && ctrl_ff.flt_src != SRC_RESERVED;
  end

  // latched fault holds until the mode is rewritten to a non-latch code, whether or not the input has gone away
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      flt_latch_ff <= 1'b0;
    end else if (i_ce) begin
      if (flt_act && ctrl_ff.flt_mode == FMODE_LATCH) begin
        flt_latch_ff <= 1'b1;
      end else if (ctrl_ff.flt_mode != FMODE_LATCH) begin
        flt_latch_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output override; fault has priority over limit
  always_comb begin
    logic f;
    f = flt_act || flt_latch_ff;
    nxt_h = i_pwm_h;
    nxt_l = i_pwm_l;
    if (ctrl_ff.ind_mode) begin
      if (lim_act) nxt_h = i_data.flt_data[1];
      if (f)       nxt_l = i_data.flt_data[0];
    end else if (f) begin
      nxt_h = i_data.flt_data[1];
      nxt_l = i_data.flt_data[0];
    end else if (lim_act) begin
      nxt_h = i_data.lim_data[1];
      nxt_l = i_data.lim_data[0];
    end
  end

  // registered outputs
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_high_side_output <= 1'b0;
      o_low_side_output  <= 1'b0;
      o_lim_active       <= 1'b0;
      o_flt_active       <= 1'b0;
    end else if (i_ce) begin
      o_high_side_output <= nxt_h;
      o_low_side_output  <= nxt_l;
      o_lim_active       <= lim_act;
      o_flt_active       <= flt_act || flt_latch_ff;
    end
  end
endmodule
